// >>> rtl/pmbm_mapper.sv
// pmbm_mapper: holds the bank select field and the start-up bit, maps
// fetch and programming addresses onto the two flash blocks
// assumes: the core drives fetch and programming requests synchronous to sys_clk;
// the reset kind is valid in the cycle rst_n is released
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - primary 64 KByte and secondary 8 KByte share one 64 KByte space
// - primary block is 512 sectors of 128 bytes
// - secondary block is 64 sectors of 128 bytes
// - low 7 address bits pick byte, upper bits pick sector
// - field 00: fetches at 0000H..1FFFH come from secondary block
// - overlay on: above 1FFFH primary; hidden primary low area via programming only
// - field 01/10/11: secondary hidden from fetch, programmable at 0000H..1FFFH
// - field loaded from start-up bit when leaving reset
// - start-up bit reads 0 programmed, 1 unprogrammed
// - power/external: bit1=0; watchdog/brown-out keep bit1; software sets bit1
// - software may rewrite field bit 0 except in the boot load cycle; start-up bit unaffected
// - start-up bit programmed by host-mode or programming command
module pmbm_mapper
   import pmbm_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire pmbm_pkg::pmbm_rst_kind_t   rst_kind,
   input  wire logic [15:0]                fetch_addr,
   input  wire logic                       iap_req,
   input  wire logic [15:0]                iap_addr,
   input  wire logic                       bank_wr,
   input  wire logic                       bank_wdata,
   input  wire logic                       sc_host_prog,
   input  wire logic                       sc_iap_prog,
   input  wire logic                       sc_wdata,
   output logic [1:0]                      bank_select_field,
   output logic                            startup_config_bit,
   output logic                            fetch_sel_sec,
   output logic [8:0]                      fetch_sector,
   output logic [6:0]                      fetch_byte,
   output logic                            iap_sel_sec,
   output logic [8:0]                      iap_sector,
   output logic [6:0]                      iap_byte
);
   import pmbm_pkg::*;

   logic       boot_pend;     // first cycle after reset release
   logic [1:0] field;
   logic       sc_cell;       // non-volatile cell, survives rst_n
   logic       sc_init = 1'b0; // low until the cell model has been erased once
   wire  logic sc_wr;
   wire  logic [1:0] boot_field;
   wire  logic [1:0] next_field;

   pmbm_decode_if fif ();
   pmbm_decode_if pif ();

   // start-up bit programming sources
   assign sc_wr = sc_host_prog | sc_iap_prog;

   // reset-kind dependent initial field value
   assign boot_field = (rst_kind == PMBM_RST_SOFT)    ? {1'b1, ~sc_cell} :
                       (rst_kind == PMBM_RST_WDT_BOD) ? {field[1], ~sc_cell} :
                                                        {1'b0, ~sc_cell};
   // field update: boot load first, then software bit 0 writes
   assign next_field = boot_pend ? boot_field
                     : bank_wr   ? {field[1], bank_wdata}
                     : field;

   // boot flag, cleared after one cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_pend <= 1'b1;
      end else begin
         boot_pend <= 1'b0;
      end
   end

   // field register; keeps bit 1 across reset for watchdog/brown-out
   always_ff @(posedge sys_clk) begin
      field <= next_field;
   end

   // start-up cell: not cleared by reset, only by its own programming strobes
   always_ff @(posedge sys_clk) begin
      if (!sc_init) begin
         sc_cell <= PMBM_SC_ERASED;
      end else if (sc_wr) begin
         sc_cell <= sc_wdata;
      end
   end

   // one-shot init of the cell model at first clock
   always_ff @(posedge sys_clk) begin
      sc_init <= 1'b1;
   end

   // decode fetch and programming addresses with the live field
   assign fif.addr = fetch_addr;
   assign fif.bank = next_field;
   assign fif.in_app_programming  = 1'b0;
   assign pif.addr = iap_addr;
   assign pif.bank = next_field;
   assign pif.in_app_programming  = iap_req;

   pmbm_decode u_fetch (.dif(fif));
   pmbm_decode u_prog  (.dif(pif));

   // registered outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_select_field  <= 2'h0;
         startup_config_bit <= 1'b1;
         fetch_sel_sec      <= 1'b0;
         fetch_sector       <= 9'h000;
         fetch_byte         <= 7'h00;
         iap_sel_sec        <= 1'b0;
         iap_sector         <= 9'h000;
         iap_byte           <= 7'h00;
      end else begin
         bank_select_field  <= next_field;
         startup_config_bit <= sc_init ? sc_cell : 1'b1;
         fetch_sel_sec      <= fif.sel_sec;
         fetch_sector       <= fif.sector;
         fetch_byte         <= fif.byte_idx;
         iap_sel_sec        <= pif.sel_sec;
         iap_sector         <= pif.sector;
         iap_byte           <= pif.byte_idx;
      end
   end
endmodule : pmbm_mapper
`default_nettype wire

// >>> rtl/pmbm_pkg.sv
// pmbm_pkg: constants and types for the program memory block mapper
// assumes: a 16-bit program address space shared by both flash blocks
package pmbm_pkg;
   localparam int          PMBM_ADDR_W        = 16;     // 64 KByte program space
   localparam int          PMBM_PRI_BYTES     = 65536;  // primary block size
   localparam int          PMBM_SEC_BYTES     = 8192;   // secondary block size
   localparam int          PMBM_SECTOR_BYTES  = 128;    // sector size, both blocks
   localparam int          PMBM_BYTE_W        = 7;      // byte-in-sector bits
   localparam int          PMBM_PRI_SECTORS   = 512;
   localparam int          PMBM_SEC_SECTORS   = 64;
   localparam int          PMBM_PRI_SECT_W    = 9;
   localparam int          PMBM_SEC_SECT_W    = 6;
   localparam int          PMBM_SEC_ADDR_W    = 13;
   localparam logic [15:0] PMBM_OVERLAY_TOP   = 16'h1FFF;
   localparam logic [1:0]  PMBM_BANK_OVERLAY  = 2'h0;   // secondary block overlaid
   localparam logic        PMBM_SC_PROGRAMMED = 1'h0;   // programmed reads as 0
   localparam logic        PMBM_SC_ERASED     = 1'h1;   // unprogrammed value, loaded into the cell model at first clock

   typedef enum logic [1:0] {
      PMBM_RST_POWER,
      PMBM_RST_WDT_BOD,
      PMBM_RST_SOFT
   } pmbm_rst_kind_t;

   typedef enum logic {
      PMBM_BLK_PRIMARY,
      PMBM_BLK_SECONDARY
   } pmbm_blk_t;
endpackage : pmbm_pkg

// >>> rtl/pmbm_decode_if.sv
// pmbm_decode_if: address and bank lines between mapper and its decoder
// assumes: one decoder instance, purely combinational
`timescale 1ns/1ps
`default_nettype none
interface pmbm_decode_if;
   logic [15:0] addr;       // program address
   logic [1:0]  bank;       // bank select field
   logic        in_app_programming;        // in-application programming access
   logic        sel_sec;    // secondary block chosen
   logic [8:0]  sector;     // sector within chosen block
   logic [6:0]  byte_idx;   // byte within sector
   modport mapper (output addr, output bank, output in_app_programming,
                   input sel_sec, input sector, input byte_idx);
   modport decoder (input addr, input bank, input in_app_programming,
                    output sel_sec, output sector, output byte_idx);
endinterface : pmbm_decode_if
`default_nettype wire

// >>> rtl/pmbm_decode.sv
// pmbm_decode: picks block, sector and byte from an address and bank field
// assumes: inputs are stable within the cycle; output is combinational
`timescale 1ns/1ps
`default_nettype none
module pmbm_decode
   import pmbm_pkg::*;
(
   pmbm_decode_if.decoder dif
);
   wire logic in_low;
   wire logic fetch_sec;

   // low 8 KByte window and block choice
   assign in_low    = (dif.addr <= PMBM_OVERLAY_TOP);
   assign fetch_sec = in_low && (dif.bank == PMBM_BANK_OVERLAY);
   // programming reaches secondary block in the low window only while hidden
   assign dif.sel_sec = dif.in_app_programming ? (in_low && (dif.bank != PMBM_BANK_OVERLAY))
                                : fetch_sec;
   // sector and byte split
   assign dif.byte_idx = dif.addr[PMBM_BYTE_W-1:0];
   assign dif.sector   = dif.sel_sec
                         ? {3'h0, dif.addr[PMBM_SEC_ADDR_W-1:PMBM_BYTE_W]}
                         : dif.addr[PMBM_ADDR_W-1:PMBM_BYTE_W];
endmodule : pmbm_decode
`default_nettype wire

// >>> verif/pmbm_core_model.sv
// pmbm_core_model: random fetch and programming traffic from the core
// assumes: runs on the mapper's sys_clk; go low holds off field writes
`timescale 1ns/1ps
`default_nettype none
module pmbm_core_model (
   input  wire logic   sys_clk, go,
   output logic [15:0] fetch_addr, iap_addr,
   output logic        iap_req, bank_wr, bank_wdata
);
   logic [15:0] next_fetch;
   initial {fetch_addr, iap_addr, iap_req, bank_wr, bank_wdata} = '0;
   // addresses lean towards the low window; field writes only from above it
   always @(posedge sys_clk) begin
      next_fetch = 16'($urandom) >> $urandom % 3;
      fetch_addr <= next_fetch;
      iap_addr <= 16'($urandom) >> $urandom % 3;
      iap_req <= 1'($urandom);
      bank_wr <= go && next_fetch > 16'h1FFF && $urandom % 3 == 0;
      bank_wdata <= 1'($urandom);
   end
endmodule : pmbm_core_model
`default_nettype wire

// >>> verif/pmbm_chk.sv
// pmbm_chk: checks of the field and the fetch decode at the ports
// assumes: bound into pmbm_mapper; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module pmbm_chk
   import pmbm_pkg::*;
(
   input wire logic sys_clk, rst_n, bank_wr, bank_wdata, fetch_sel_sec, startup_config_bit,
   input wire logic [15:0] fetch_addr,
   input wire logic [1:0] bank_select_field,
   input wire logic [8:0] fetch_sector,
   input wire logic [6:0] fetch_byte,
   input wire pmbm_pkg::pmbm_rst_kind_t rst_kind
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // boot: field just loaded; booted: history free of reset values
   sequence boot_s; $past(rst_n) && !$past(rst_n, 2) && $past(rst_kind) != PMBM_RST_WDT_BOD; endsequence
   sequence booted_s; $past(rst_n, 2); endsequence
   boot_load_a: assert property (boot_s |->
      bank_select_field == {$past(rst_kind) == PMBM_RST_SOFT, ~startup_config_bit}) else $error("boot load");
   fetch_block_a: assert property (booted_s |-> fetch_sel_sec ==
      (bank_select_field == 2'h0 && $past(fetch_addr) <= 16'h1FFF)) else $error("fetch block");
   fetch_sector_a: assert property (booted_s |-> fetch_sector == (fetch_sel_sec ?
      {3'h0, $past(fetch_addr[12:7])} : $past(fetch_addr[15:7]))) else $error("sector");
   fetch_byte_a: assert property (booted_s |-> fetch_byte == $past(fetch_addr[6:0]))
      else $error("byte");
   bank_write_a: assert property (booted_s ##0 $past(bank_wr) |->
      bank_select_field == {$past(bank_select_field[1]), $past(bank_wdata)}) else $error("write");
   bank_hold_a: assert property (booted_s ##0 !$past(bank_wr) |-> $stable(bank_select_field))
      else $error("field moved");
   high_primary_a: assert property ($past(fetch_addr) > 16'h1FFF |-> !fetch_sel_sec)
      else $error("high fetch");
   overlay_off_a: assert property (booted_s ##0 bank_select_field != 2'h0 |-> !fetch_sel_sec)
      else $error("hidden block");
endmodule : pmbm_chk
bind pmbm_mapper pmbm_chk u_chk (.*);
`default_nettype wire

// >>> verif/test_program_memory_block_mapper.sv
// test_program_memory_block_mapper: core traffic against a reference model
// assumes: mapper, checker and core model compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_program_memory_block_mapper;
   import pmbm_pkg::*;
   logic sys_clk = 1'h0, rst_n = 1'h0, go = 1'h0, sc_wdata = 1'h0, sc_host_prog = 1'h0;
   logic sc_iap_prog = 1'h0, m_sc = 1'h1, ir, ok, iap_req, bank_wr, bank_wdata;
   logic startup_config_bit, fetch_sel_sec, iap_sel_sec;
   logic [1:0] bank_select_field, m_field = 2'h0;
   logic [15:0] fetch_addr, iap_addr, fa, ia;
   logic [8:0] fetch_sector, iap_sector;
   logic [6:0] fetch_byte, iap_byte;
   pmbm_rst_kind_t rst_kind = PMBM_RST_POWER;
   int num_errors = 0, checked = 0, cyc = 0, age = 0;
   int kinds[5] = '{0, 0, 2, 1, 1}, progs[5] = '{0, 1, 0, 0, 2}; // 1 host clears, 2 in-app sets
   pmbm_mapper uut (.*);
   pmbm_core_model core (.*);
   always #4 sys_clk = ~sys_clk;
   function automatic logic [16:0] dec(logic [15:0] ad, logic sec);
      return {sec, sec ? {3'h0, ad[12:7]} : ad[15:7], ad[6:0]};
   endfunction : dec
   task automatic chk(logic [16:0] got, logic [16:0] exp);
      checked++;
      num_errors += int'(got !== exp);
      if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
   endtask : chk
   task automatic close_out(int hung);
      num_errors += hung;
      $display("%0d compared, %0d bad", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   // reference model of field, start-up bit and decode, compared after each edge
   always @(posedge sys_clk) begin
      if (++cyc == 3000) close_out(1);
      {fa, ir, ia, ok} = {fetch_addr, iap_req, iap_addr, rst_n && age > 0};
      if (!rst_n) age = 0;
      else if (age++ == 0) begin
         if (rst_kind != PMBM_RST_WDT_BOD) m_field[1] = rst_kind == PMBM_RST_SOFT;
         m_field[0] = ~m_sc;
      end else begin
         if (bank_wr) m_field[0] = bank_wdata;
         if (sc_host_prog || sc_iap_prog) m_sc = sc_wdata;
      end
      #1;
      if (ok && rst_n) begin
         chk({fetch_sel_sec, fetch_sector, fetch_byte}, dec(fa, ~|{m_field, fa[15:13]}));
         if (ir) chk({iap_sel_sec, iap_sector, iap_byte}, dec(ia, |m_field & ~|ia[15:13]));
         chk({14'h0, bank_select_field, startup_config_bit}, {14'h0, m_field, m_sc});
      end
   end
   // per test: optional start-up bit write, reset of one kind, then traffic
   initial begin
      void'($urandom(32'hA3B5));
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         sc_wdata <= progs[i] == 2;
         {sc_host_prog, sc_iap_prog} <= {progs[i] == 1, progs[i] == 2};
         @(posedge sys_clk);
         {sc_host_prog, sc_iap_prog, go, rst_n} <= 4'h0;
         rst_kind <= pmbm_rst_kind_t'(kinds[i]);
         repeat (6) @(posedge sys_clk);
         rst_n <= 1'h1;
         repeat (3) @(posedge sys_clk);
         go <= 1'h1;
         repeat (300) @(posedge sys_clk);
         $display("test %0d done, %0d bad so far", i, num_errors);
      end
      close_out(0);
   end
endmodule : test_program_memory_block_mapper
`default_nettype wire
